//--- rtl/data_mem_pkg.sv
// data_mem_pkg: constants shared by the banked data memory decoder.
// assumes a 14-bit linear data address split into bank and offset.
package data_mem_pkg;

  // address geometry
  localparam int BANK_W = 6;
  localparam int OFFS_W = 8;
  localparam int ADDR_W = BANK_W + OFFS_W;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 64;
  localparam int BANK_BYTES = 256;

  // fast-access bank split: low offsets reach ram, high offsets reach sfrs
  localparam logic [OFFS_W-1:0] FAST_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] FAST_RAM_BANK = 6'h05;
  localparam logic [BANK_W-1:0] FAST_SFR_BANK = 6'h04;

  // location of the bank pointer inside the special function register space
  localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 14'h04E0;

  // reset value of the bank pointer
  localparam logic [BANK_W-1:0] BANK_PTR_RESET = 6'h00;

  // default count of populated banks, counted from bank 0
  localparam int IMPL_BANKS_DEF = 16;

  // which path formed the current address
  typedef enum logic [1:0] {
    PATH_FAST,
    PATH_BANKED,
    PATH_INDEXED,
    PATH_POINTER
  } addr_path_t;

  // true when the bank holding addr is populated
  function automatic logic is_implemented(
    input logic [ADDR_W-1:0] addr,
    input int impl_banks
  );
    is_implemented = (int'(addr[ADDR_W-1:OFFS_W]) < impl_banks);
  endfunction : is_implemented

endpackage : data_mem_pkg

//--- rtl/addr_former.sv
// addr_former: combinational forming of the full data address.
// assumes all inputs are stable within the cycle of the request.
`timescale 1ns/1ps
`default_nettype none

module addr_former (
  // instruction address fields
  input wire logic [data_mem_pkg::OFFS_W-1:0] offset,
  input wire logic access_sel,
  input wire logic use_pointer,
  // address sources
  input wire logic [data_mem_pkg::BANK_W-1:0] bank_ptr,
  input wire logic [data_mem_pkg::ADDR_W-1:0] pointer_addr,
  input wire logic [data_mem_pkg::ADDR_W-1:0] index_base,
  input wire logic extended_instr_enable,
  // result
  output logic [data_mem_pkg::ADDR_W-1:0] full_addr,
  output data_mem_pkg::addr_path_t path
);
  import data_mem_pkg::*;

  // pointer first, then banked, then the fast-access map
  always_comb begin
    full_addr = '0;
    path = PATH_FAST;
    if (use_pointer) begin
      full_addr = pointer_addr; // R12
      path = PATH_POINTER;
    end else if (access_sel) begin
      full_addr = {bank_ptr, offset}; // R03 R04
      path = PATH_BANKED;
    end else if (offset < FAST_SPLIT) begin
      if (extended_instr_enable) begin
        // alternate map: low offsets index from the base pointer
        full_addr = ADDR_W'(index_base + ADDR_W'(offset)); // R11
        path = PATH_INDEXED;
      end else begin
        full_addr = {FAST_RAM_BANK, offset}; // R05 R06
      end
    end else begin
      full_addr = {FAST_SFR_BANK, offset}; // R05 R07
    end
  end

endmodule : addr_former

`default_nettype wire

//--- rtl/banked_data_memory_decoder.sv
// banked_data_memory_decoder: turns core access requests into strobes for
// the physical data ram, owns the bank pointer, and hides unpopulated banks.
// assumes the ram reads asynchronously from mem_addr and writes on the edge
// after mem_we is seen; the core holds a request for exactly one cycle.
// assumes populated banks count up from bank 0 and that a bank is either
// fully present or absent; a partly filled bank reads as populated.
// mem_addr follows the formed address every cycle, request or not; only
// mem_rd and mem_we tell the ram to act, which saves a hold mux.
//
// Functional notes
// R01: sixty-four banks of 256 bytes, linear
// R02: unimplemented reads give zero, writes dropped
// R03: banked address is bank pointer over offset
// R04: access-select one uses bank pointer
// R05: access-select zero uses fast-access map
// R06: fast offsets 00-5F reach bank five ram
// R07: fast offsets 60-FF reach bank four sfrs
// R08: fast access completes in one cycle; here the read answer comes two cycles after the request, as for banked access
// R09: bank pointer loaded by literal or sfr
// R10: every bank selectable, all paths reach memory
// R11: extended enable selects alternate fast map
// R12: pointer access uses full address, any bank
// R13: bank pointer clears to zero on reset
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_decoder #(
  parameter int IMPL_BANKS = data_mem_pkg::IMPL_BANKS_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // core access request
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [data_mem_pkg::OFFS_W-1:0] offset,
  input wire logic access_sel,
  input wire logic use_pointer,
  input wire logic [data_mem_pkg::ADDR_W-1:0] pointer_addr,
  input wire logic [data_mem_pkg::ADDR_W-1:0] index_base,
  input wire logic [data_mem_pkg::DATA_W-1:0] wr_data,
  // bank pointer literal load
  input wire logic load_bank_literal_instr,
  input wire logic [data_mem_pkg::BANK_W-1:0] bank_literal,
  // configuration
  input wire logic extended_instr_enable,
  // core answer
  output logic rd_valid,
  output logic [data_mem_pkg::DATA_W-1:0] rd_data,
  output logic [data_mem_pkg::BANK_W-1:0] bank_pointer_reg,
  // physical ram port
  output logic [data_mem_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_we,
  output logic [data_mem_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [data_mem_pkg::DATA_W-1:0] mem_rdata
);
  import data_mem_pkg::*;

  logic [BANK_W-1:0] bank_q;
  logic [BANK_W-1:0] bank_d;
  logic [ADDR_W-1:0] full_addr;
  // decode results for the request in this cycle
  logic impl_hit;
  logic ptr_hit;
  logic sfr_bank_wr;
  logic rd_ok;
  logic wr_ok;
  logic [ADDR_W-1:0] addr_q;
  logic rd_q;
  logic we_q;
  logic [DATA_W-1:0] wdata_q;
  logic pend_rd_q;
  logic pend_impl_q;
  logic pend_ptr_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;

  // one qualification for both ram strobes, so reads and writes can never
  // disagree about which locations the ram owns
  function automatic logic ram_strobe(
    input logic req,
    input logic populated,
    input logic at_pointer
  );
    ram_strobe = req && populated && !at_pointer;
  endfunction : ram_strobe

  // address forming is purely combinational, so a fast-access request is
  // decoded in the cycle it arrives with no bank pointer update first
  addr_former u_addr_former (
    .offset(offset),
    .access_sel(access_sel),
    .use_pointer(use_pointer),
    .bank_ptr(bank_q),
    .pointer_addr(pointer_addr),
    .index_base(index_base),
    .extended_instr_enable(extended_instr_enable),
    .full_addr(full_addr),
    .path()
  ); // R08 R10

  // population check and bank pointer's own sfr slot; population is
  // judged by bank alone, the pointer slot is recognised apart
  assign impl_hit = is_implemented(full_addr, IMPL_BANKS); // R01
  assign ptr_hit = (full_addr == BANK_PTR_ADDR);

  // the core writes the pointer like any other sfr; this write skips the
  // population check so the pointer stays reachable with few banks fitted
  assign sfr_bank_wr = wr_req && ptr_hit; // R09

  // the ram only sees requests inside a populated bank and away from the
  // pointer slot; a refused write simply never strobes
  assign rd_ok = ram_strobe(rd_req, impl_hit, ptr_hit); // R02
  assign wr_ok = ram_strobe(wr_req, impl_hit, ptr_hit); // R02

  // next bank pointer: the literal load wins over a same-cycle sfr write,
  // since the core cannot issue both from one instruction anyway
  always_comb begin
    bank_d = bank_q;
    if (load_bank_literal_instr) begin
      bank_d = bank_literal; // R09
    end else if (sfr_bank_wr) begin
      bank_d = wr_data[BANK_W-1:0]; // R09 R10
    end
  end

  // bank pointer register; clearing it selects bank 0 until software
  // loads another value
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_q <= BANK_PTR_RESET; // R13
    end else begin
      bank_q <= bank_d;
    end
  end

  // ram address and write data follow the core every cycle; only the
  // strobes say whether the ram should act on them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      addr_q <= full_addr;
      wdata_q <= wr_data;
    end
  end

  // ram strobes; the pointer slot is served here, not by the ram
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      rd_q <= rd_ok;
      we_q <= wr_ok; // R02
    end
  end

  // a read in flight; this alone times the answer two edges after the
  // request, whatever the target turns out to be
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_rd_q <= 1'b0;
    end else begin
      pend_rd_q <= rd_req; // R08
    end
  end

  // where the read in flight landed, captured with the request because
  // the address inputs may already hold the next request by the answer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_impl_q <= 1'b0;
      pend_ptr_q <= 1'b0;
    end else begin
      pend_impl_q <= impl_hit;
      pend_ptr_q <= ptr_hit;
    end
  end

  // read answer: a hole in the map reads as zero rather than stale data,
  // and the byte holds between answers so the core may take it late
  always_comb begin
    rd_data_d = rd_data_q;
    if (pend_rd_q) begin
      if (pend_ptr_q) begin
        rd_data_d = DATA_W'(bank_q);
      end else if (pend_impl_q) begin
        rd_data_d = mem_rdata;
      end else begin
        rd_data_d = '0; // R02
      end
    end
  end

  // read answer registers; valid is a one-cycle pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= pend_rd_q;
      rd_data_q <= rd_data_d;
    end
  end

  // outputs straight from flip-flops, so neither the core nor the ram
  // ever sees a decode glitch
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign bank_pointer_reg = bank_q;
  assign mem_addr = addr_q;
  assign mem_rd = rd_q;
  assign mem_we = we_q;
  assign mem_wdata = wdata_q;

endmodule : banked_data_memory_decoder

`default_nettype wire

//--- verif/ram_model.sv
// ram_model: physical data ram seen behind the decoder's ram port.
// assumes reads follow the address at once and writes land on the clock.
`timescale 1ns/1ps
`default_nettype none
module ram_model (
  // ram port
  input wire logic ref_clk,
  input wire logic [13:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [16384];
  // byte lands on the edge after the strobe is seen
  always_ff @(posedge ref_clk) begin
    if (mem_we) store[mem_addr] <= mem_wdata;
  end
  // unselected: inverse value, so stale data never passes for a hit
  assign mem_rdata = mem_rd ? store[mem_addr] : ~store[mem_addr];
endmodule : ram_model
`default_nettype wire

//--- verif/decoder_properties.sv
// decoder_properties: port timing and address mapping checks.
// assumes it is bound onto every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module decoder_chk #(
  parameter int IMPL_BANKS = data_mem_pkg::IMPL_BANKS_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // core request
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic access_sel,
  input wire logic use_pointer,
  input wire logic extended_instr_enable,
  input wire logic [data_mem_pkg::OFFS_W-1:0] offset,
  input wire logic [data_mem_pkg::ADDR_W-1:0] pointer_addr,
  input wire logic [data_mem_pkg::ADDR_W-1:0] index_base,
  input wire logic [data_mem_pkg::DATA_W-1:0] wr_data,
  // bank pointer load
  input wire logic load_bank_literal_instr,
  input wire logic [data_mem_pkg::BANK_W-1:0] bank_literal,
  // core answer
  input wire logic rd_valid,
  input wire logic [data_mem_pkg::DATA_W-1:0] rd_data,
  input wire logic [data_mem_pkg::BANK_W-1:0] bank_pointer_reg,
  // ram port
  input wire logic [data_mem_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_we,
  input wire logic [data_mem_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [data_mem_pkg::DATA_W-1:0] mem_rdata
);
  import data_mem_pkg::*;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // standard fast map request; extended mode offsets below FAST_SPLIT are checked by chk_ext_map
  wire logic req = rd_req | wr_req;
  wire logic fast = req & ~access_sel & ~use_pointer & ~extended_instr_enable;
  chk_rd_answer: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer not two cycles on");
  chk_wr_popul: assert property (mem_we |-> mem_addr[13:8] < IMPL_BANKS)
    else $error("write strobe to unpopulated bank");
  chk_rd_zero: assert property (rd_valid && !$past(mem_rd) &&
    $past(mem_addr) != BANK_PTR_ADDR |-> rd_data == 8'h00)
    else $error("unpopulated read not zero");
  chk_rd_data: assert property (rd_valid && $past(mem_rd) |->
    rd_data == $past(mem_rdata)) else $error("read data not from ram");
  chk_banked_addr: assert property (req && access_sel && !use_pointer
    |=> mem_addr == {$past(bank_pointer_reg), $past(offset)})
    else $error("banked address wrong");
  chk_fast_map: assert property (fast |=> mem_addr ==
    {($past(offset) < FAST_SPLIT) ? FAST_RAM_BANK : FAST_SFR_BANK,
    $past(offset)})
    else $error("fast map address wrong");
  chk_pointer_addr: assert property (req && use_pointer |=>
    mem_addr == $past(pointer_addr)) else $error("pointer address wrong");
  chk_literal_load: assert property (load_bank_literal_instr |=>
    bank_pointer_reg == $past(bank_literal)) else $error("literal not loaded");
  chk_wr_source: assert property (mem_we |-> $past(wr_req))
    else $error("write strobe without request");
  chk_wr_data: assert property (mem_we |-> mem_wdata == $past(wr_data))
    else $error("ram write data differs from request data");
  chk_ext_map: assert property (req && !access_sel && !use_pointer &&
    extended_instr_enable && offset < FAST_SPLIT |=>
    mem_addr == $past(index_base) + $past(offset))
    else $error("extended map address wrong");
  cover property (rd_valid && $past(mem_rd));
  cover property (req && extended_instr_enable && !access_sel ##1 mem_we);
  cover property (fast ##1 mem_we);
  cover property (rd_valid && rd_data == 8'h00 && !$past(mem_rd));
endmodule : decoder_chk
bind banked_data_memory_decoder decoder_chk #(.IMPL_BANKS(IMPL_BANKS)) chk_u (
  .ref_clk, .sys_rst, .rd_req, .wr_req, .access_sel, .use_pointer,
  .load_bank_literal_instr, .mem_we, .extended_instr_enable, .rd_valid,
  .mem_rd, .offset, .rd_data, .mem_rdata, .bank_literal, .bank_pointer_reg,
  .pointer_addr, .mem_addr, .index_base, .wr_data, .mem_wdata);
`default_nettype wire

//--- verif/testbench.sv
// testbench: directed scenarios for the banked data memory decoder.
// assumes ram_model answers the ram port; six banks populated.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, sys_rst = 1, rd_req = 0, wr_req = 0, access_sel = 0;
  logic use_pointer = 0, load_bank_literal_instr = 0;
  logic extended_instr_enable = 0, rd_valid, mem_rd, mem_we;
  logic [7:0] offset = 0, wr_data = 0, rd_data, mem_wdata, mem_rdata;
  logic [13:0] pointer_addr = 0, index_base = 0, mem_addr;
  logic [5:0] bank_literal = 0, bank_pointer_reg;
  int n_errors = 0, total_checks = 0, cycles = 0;
  always #5 ref_clk = ~ref_clk;
  banked_data_memory_decoder #(.IMPL_BANKS(6)) dut_u (.*);
  ram_model ram_u (.*);
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // hang guard: the run needs about 55 cycles
  always @(posedge ref_clk) begin
    if (++cycles > 3000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic cmp(input logic [13:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // one request pulse; returns in the cycle where a read answer stands
  task automatic acc(input logic w, s, p, input logic [7:0] o, d);
    {wr_req, rd_req, access_sel, use_pointer} = {w, !w, s, p};
    {offset, wr_data} = {o, d};
    step(1);
    {wr_req, rd_req} = 2'h0;
    step(1);
  endtask : acc
  task automatic rd_chk(input logic s, p, input logic [7:0] o, e);
    acc(1'h0, s, p, o, 8'h00);
    cmp(rd_valid, 1'h1);
    cmp(rd_data, e);
  endtask : rd_chk
  task automatic lb(input logic [5:0] v);
    {load_bank_literal_instr, bank_literal} = {1'h1, v};
    step(1);
    load_bank_literal_instr = 0;
    cmp(bank_pointer_reg, v);
  endtask : lb
  task automatic t_ram();
    cmp(bank_pointer_reg, 6'h00);
    lb(6'h05);
    acc(1'h1, 1'h1, 1'h0, 8'h10, 8'hA5);
    rd_chk(1'h0, 1'h0, 8'h10, 8'hA5);
    acc(1'h1, 1'h0, 1'h0, 8'h70, 8'h3C);
    lb(6'h04);
    rd_chk(1'h1, 1'h0, 8'h70, 8'h3C);
  endtask : t_ram
  task automatic t_pointer();
    lb(6'h09);
    pointer_addr = 14'h0510;
    rd_chk(1'h0, 1'h1, 8'h00, 8'hA5);
  endtask : t_pointer
  task automatic t_unimpl();
    lb(6'h06);
    acc(1'h1, 1'h1, 1'h0, 8'h11, 8'h5A);
    rd_chk(1'h1, 1'h0, 8'h11, 8'h00);
    lb(6'h3F);
    rd_chk(1'h1, 1'h0, 8'hFF, 8'h00);
  endtask : t_unimpl
  task automatic t_sfr_bank();
    acc(1'h1, 1'h0, 1'h0, 8'hE0, 8'h2A);
    cmp(bank_pointer_reg, 6'h2A);
    rd_chk(1'h0, 1'h0, 8'hE0, 8'h2A);
  endtask : t_sfr_bank
  task automatic t_ext();
    {extended_instr_enable, index_base} = {1'h1, 14'h0300};
    acc(1'h1, 1'h0, 1'h0, 8'h05, 8'h77);
    rd_chk(1'h0, 1'h0, 8'h70, 8'h3C);
    extended_instr_enable = 0;
    lb(6'h03);
    rd_chk(1'h1, 1'h0, 8'h05, 8'h77);
  endtask : t_ext
  // mid-run reset: a loaded pointer and the last read byte clear again
  task automatic t_reset();
    lb(6'h2A);
    sys_rst = 1;
    step(2);
    cmp(bank_pointer_reg, 6'h00);
    cmp(rd_valid, 1'h0);
    cmp(rd_data, 8'h00);
    sys_rst = 0;
    step(1);
    rd_chk(1'h0, 1'h0, 8'h10, 8'hA5);
  endtask : t_reset
  initial begin
    step(16);
    sys_rst = 0;
    step(1);
    t_ram();
    t_pointer();
    t_unimpl();
    t_sfr_bank();
    t_ext();
    t_reset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
